// File: logic/vbis_pkg.sv
// Operation
// - Reading a data register or the FIFO never clears any status flag.
// - Writing one clears a sticky flag; zero leaves it; FIFO-empty is always live.
// - A line that cannot fit whole in the FIFO is dropped and sets full-error.
// - A later line that fits is written even while full-error stays set.
// - Status C6h bits: full-error, empty, teletext, caption f1, caption f2, WSS, VPS, VITC.
// - Register C7h shows the number of 16-bit words held in the FIFO.
// - Threshold condition is raised while word count exceeds threshold (reset 80h).
// - Counts and thresholds are in two-byte words, not bytes.
// - Any write to C9h empties the FIFO and discards its data.
// - Line condition fires when the video line equals bits 5:0 of CAh.
// - A programmed line of zero or one never fires the line condition.
// - A 10-bit pixel count from sync fall sets when line settings load.
// - Host access one drains FIFO by register reads; zero drains to video port.
// - Full-field mode slices non-blanking lines and FFh lines with FCh settings.
// - One line-mode register per line 6..27 and field at D0h..FBh.
// - Bit 7 enables caption null removal or teletext filter; zero passes all.
// - Bit 6 zero sends data to registers only; teletext always FIFO only.
// - Bit 5 one keeps errored data out of the FIFO.
// - Bit 4 enables error correction only for standard codes 1 to 4.
// - Bits 3:0 encode the standard; 1111 means active video, slicing off.
// - FCh uses line-mode coding, resets 7Fh; non-FFh line registers override it.
// - Enables only gate the pin; status bits set regardless.
package vbis_pkg;

	localparam int unsigned REG_AW     = 8;
	localparam int unsigned REG_DW     = 8;
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned PTR_W      = 8;
	localparam int unsigned FIFO_DEPTH = 256;
	localparam int unsigned LINE_W     = 10;
	localparam int unsigned PIX_W      = 10;
	localparam int unsigned LEN_W      = 9;
	localparam int unsigned LM_COUNT   = 44;
	localparam int unsigned LM_IDX_W   = 6;

	// One slot kept free so pointers alone never alias full and empty
	localparam logic [8:0] FIFO_CAP = 9'h0FF;

	localparam logic [7:0] OFS_STATUS    = 8'hC6;
	localparam logic [7:0] OFS_WCOUNT    = 8'hC7;
	localparam logic [7:0] OFS_THRESH    = 8'hC8;
	localparam logic [7:0] OFS_FLUSH     = 8'hC9;
	localparam logic [7:0] OFS_LINE_IRQ  = 8'hCA;
	localparam logic [7:0] OFS_SW_LO     = 8'hCB;
	localparam logic [7:0] OFS_SW_HI     = 8'hCC;
	localparam logic [7:0] OFS_DRAIN     = 8'hCD;
	localparam logic [7:0] OFS_FIFO_DATA = 8'hCE;
	localparam logic [7:0] OFS_FF_EN     = 8'hCF;
	localparam logic [7:0] OFS_LM_FIRST  = 8'hD0;
	localparam logic [7:0] OFS_LM_LAST   = 8'hFB;
	localparam logic [7:0] OFS_FF_MODE   = 8'hFC;

	localparam logic [7:0] RST_THRESH   = 8'h80;
	localparam logic [7:0] RST_LINE_IRQ = 8'h00;
	localparam logic [7:0] RST_SW_LO    = 8'h4E;
	localparam logic [1:0] RST_SW_HI    = 2'h0;
	localparam logic       RST_DRAIN    = 1'b1;
	localparam logic       RST_FF_EN    = 1'b0;
	localparam logic [7:0] RST_LM_FIRST = 8'h00;
	localparam logic [7:0] RST_LM_REST  = 8'hFF;
	localparam logic [7:0] RST_FF_MODE  = 8'h7F;
	localparam logic [7:0] LM_OFF       = 8'hFF;

	localparam int unsigned ST_FULL_ERR = 7;
	localparam int unsigned ST_EMPTY    = 6;
	localparam int unsigned ST_TTX      = 5;
	localparam int unsigned ST_CC1      = 4;
	localparam int unsigned ST_CC2      = 3;
	localparam int unsigned ST_WSS      = 2;
	localparam int unsigned ST_VPS      = 1;
	localparam int unsigned ST_VITC     = 0;
	localparam logic [7:0]  FLAG_MASK   = 8'hBF;

	localparam int unsigned LM_FILTER = 7;
	localparam int unsigned LM_FIFO   = 6;
	localparam int unsigned LM_ERRBLK = 5;
	localparam int unsigned LM_EDC    = 4;
	localparam int unsigned LNI_F1    = 7;
	localparam int unsigned LNI_F2    = 6;
	localparam int unsigned CTRL_BIT  = 0;

	localparam logic [LINE_W-1:0] FIRST_LINE = 10'h006;
	localparam logic [LINE_W-1:0] LAST_LINE  = 10'h01B;
	localparam logic [5:0]        LNI_MIN    = 6'h02;
	localparam logic [PIX_W-1:0]  PIX_MAX    = 10'h3FF;

	localparam logic [3:0] STD_TTX_LO = 4'h0;
	localparam logic [3:0] STD_TTX_HI = 4'h5;
	localparam logic [3:0] STD_CC_LO  = 4'h6;
	localparam logic [3:0] STD_CC_HI  = 4'h7;
	localparam logic [3:0] STD_WSS_LO = 4'h8;
	localparam logic [3:0] STD_WSS_HI = 4'h9;
	localparam logic [3:0] STD_VIT_LO = 4'hA;
	localparam logic [3:0] STD_VIT_HI = 4'hB;
	localparam logic [3:0] STD_VPS    = 4'hC;
	localparam logic [3:0] STD_EDC_LO = 4'h1;
	localparam logic [3:0] STD_EDC_HI = 4'h4;
	localparam logic [3:0] STD_OFF    = 4'hF;

	function automatic logic std_in(input logic [3:0] code, input logic [3:0] lo,
		input logic [3:0] hi);
		return (code >= lo) && (code <= hi);
	endfunction : std_in

endpackage : vbis_pkg

// File: logic/vbis_word_mem.sv
`timescale 1ns/1ps
module vbis_word_mem #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 256,
	parameter int unsigned AW    = 8
) (
	// Clock
	input  wire logic             clk_i,
	// Write side
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// Read side
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_q[raddr_i];
	end

endmodule : vbis_word_mem

// File: logic/vbis_ctrl.sv
`timescale 1ns/1ps
module vbis_ctrl (
	// Clock and reset
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_i,
	// Register port from the serial host interface
	input  wire logic                          reg_wr_i,
	input  wire logic                          reg_rd_i,
	input  wire logic [vbis_pkg::REG_AW-1:0]   reg_addr_i,
	input  wire logic [vbis_pkg::REG_DW-1:0]   reg_wdata_i,
	output logic      [vbis_pkg::REG_DW-1:0]   reg_rdata_o,
	// Video timing
	input  wire logic                          pix_clk_i,
	input  wire logic                          hsync_n_i,
	input  wire logic [vbis_pkg::LINE_W-1:0]   line_num_i,
	input  wire logic                          field2_i,
	// Sliced line from the slicer core
	input  wire logic                          slc_start_i,
	input  wire logic [vbis_pkg::LEN_W-1:0]    slc_len_i,
	input  wire logic                          slc_err_i,
	input  wire logic                          slc_word_valid_i,
	input  wire logic [vbis_pkg::WORD_W-1:0]   slc_word_i,
	input  wire logic                          slc_done_i,
	// Settings to the slicer core
	output logic      [3:0]                    std_o,
	output logic                               null_filter_o,
	output logic                               data_filter_o,
	output logic                               edc_en_o,
	output logic                               to_fifo_o,
	output logic                               to_regs_o,
	output logic                               drop_err_o,
	// Video port drain
	output logic      [7:0]                    vid_y_o,
	output logic                               vid_valid_o,
	// Interrupt conditions
	output logic                               irq_thresh_o,
	output logic                               irq_line_o
);
	localparam int unsigned CW = vbis_pkg::PTR_W;

	// Two-stage synchronisers for the pin-side timing
	logic [1:0] pix_s_q;
	logic [1:0] hs_s_q;
	logic       pix_prev_q;
	logic       hs_prev_q;

	logic [7:0]                   flags_q;
	logic [7:0]                   thresh_q;
	logic [7:0]                   lni_q;
	logic [7:0]                   sw_lo_q;
	logic [1:0]                   sw_hi_q;
	logic                         drain_q;
	logic                         ff_en_q;
	logic [7:0]                   ff_mode_q;
	logic [7:0]                   lm_q [vbis_pkg::LM_COUNT];
	logic [7:0]                   cur_mode_q;
	logic [vbis_pkg::PIX_W-1:0]   px_q;
	logic [CW-1:0]                count_q;
	logic [CW-1:0]                wr_ptr_q;
	logic [CW-1:0]                rd_ptr_q;
	logic                         byte_sel_q;
	logic                         head_ok_q;
	logic                         line_acc_q;
	logic [7:0]                   reg_rdata_q;
	logic [7:0]                   vid_y_q;
	logic                         vid_valid_q;
	logic                         irq_thresh_q;
	logic                         irq_line_q;
	logic [vbis_pkg::WORD_W-1:0]  head_word;

	// Edges
	wire pix_rise = pix_s_q[1] & ~pix_prev_q;
	wire hs_fall  = ~hs_s_q[1] & hs_prev_q;

	// Address decode
	wire wr_status = reg_wr_i && (reg_addr_i == vbis_pkg::OFS_STATUS);
	wire wr_flush  = reg_wr_i && (reg_addr_i == vbis_pkg::OFS_FLUSH);
	wire in_lm     = (reg_addr_i >= vbis_pkg::OFS_LM_FIRST) &&
		(reg_addr_i <= vbis_pkg::OFS_LM_LAST);
	wire wr_lm     = reg_wr_i && in_lm;
	wire [vbis_pkg::LM_IDX_W-1:0] lm_widx = 6'(reg_addr_i - vbis_pkg::OFS_LM_FIRST);

	// Mode for the line now running
	wire [vbis_pkg::LINE_W-1:0] line_off = line_num_i - vbis_pkg::FIRST_LINE;
	wire in_vbi  = (line_num_i >= vbis_pkg::FIRST_LINE) &&
		(line_num_i <= vbis_pkg::LAST_LINE);
	wire [vbis_pkg::LM_IDX_W-1:0] lm_ridx = {line_off[4:0], field2_i};
	wire [7:0] lm_sel = in_vbi ? lm_q[lm_ridx] : vbis_pkg::LM_OFF;
	wire lm_own = in_vbi && (lm_sel != vbis_pkg::LM_OFF);
	// Lines above the blanking run follow full field; lines below it carry sync
	wire ff_take = ff_en_q && (in_vbi || (line_num_i > vbis_pkg::LAST_LINE));
	wire [7:0] eff_mode = lm_own ? lm_sel :
		(ff_take ? ff_mode_q : vbis_pkg::LM_OFF);
	wire [9:0] sw_pos = {sw_hi_q, sw_lo_q};
	wire switch_hit = pix_rise && (px_q == sw_pos);

	// Decode of the active mode
	wire [3:0] cur_std = cur_mode_q[3:0];
	wire is_ttx  = vbis_pkg::std_in(cur_std, vbis_pkg::STD_TTX_LO, vbis_pkg::STD_TTX_HI);
	wire is_cc   = vbis_pkg::std_in(cur_std, vbis_pkg::STD_CC_LO, vbis_pkg::STD_CC_HI);
	wire is_wss  = vbis_pkg::std_in(cur_std, vbis_pkg::STD_WSS_LO, vbis_pkg::STD_WSS_HI);
	wire is_vitc = vbis_pkg::std_in(cur_std, vbis_pkg::STD_VIT_LO, vbis_pkg::STD_VIT_HI);
	wire is_vps  = (cur_std == vbis_pkg::STD_VPS);
	wire slicing = (cur_std != vbis_pkg::STD_OFF);

	assign std_o         = cur_std;
	assign null_filter_o = is_cc && cur_mode_q[vbis_pkg::LM_FILTER];
	assign data_filter_o = is_ttx && cur_mode_q[vbis_pkg::LM_FILTER];
	assign edc_en_o      = cur_mode_q[vbis_pkg::LM_EDC] &&
		vbis_pkg::std_in(cur_std, vbis_pkg::STD_EDC_LO, vbis_pkg::STD_EDC_HI);
	assign to_fifo_o     = slicing && (cur_mode_q[vbis_pkg::LM_FIFO] || is_ttx);
	assign to_regs_o     = slicing && !is_ttx;
	assign drop_err_o    = cur_mode_q[vbis_pkg::LM_ERRBLK];

	// FIFO admission: a line goes in whole or not at all
	wire [8:0] free_words = vbis_pkg::FIFO_CAP - {1'b0, count_q};
	wire want_fifo = slc_start_i && to_fifo_o && !(slc_err_i && drop_err_o);
	wire fits      = (slc_len_i <= free_words);
	wire reject    = want_fifo && !fits;
	wire admit     = want_fifo && fits && !wr_flush;
	wire fifo_full = ({1'b0, count_q} == vbis_pkg::FIFO_CAP);
	wire push      = line_acc_q && slc_word_valid_i && !fifo_full && !wr_flush;

	// Drain: two bytes per word, upper byte first, on either path
	wire rd_fifo   = reg_rd_i && (reg_addr_i == vbis_pkg::OFS_FIFO_DATA);
	wire host_take = rd_fifo && drain_q && head_ok_q;
	wire vid_take  = !drain_q && pix_rise && head_ok_q;
	wire take      = host_take || vid_take;
	wire pop       = take && byte_sel_q && !wr_flush;
	wire [7:0] head_byte = byte_sel_q ? head_word[7:0] : head_word[15:8];
	wire [CW-1:0] count_d = wr_flush ? '0 :
		CW'(count_q + CW'(push) - CW'(pop));
	wire fifo_empty = (count_q == '0);

	// Sticky flags: set wins over a same-cycle write-one clear
	wire [7:0] set_v;
	assign set_v[vbis_pkg::ST_FULL_ERR] = reject;
	assign set_v[vbis_pkg::ST_EMPTY]    = 1'b0;
	assign set_v[vbis_pkg::ST_TTX]      = admit && is_ttx;
	assign set_v[vbis_pkg::ST_CC1]      = slc_done_i && is_cc && !field2_i;
	assign set_v[vbis_pkg::ST_CC2]      = slc_done_i && is_cc && field2_i;
	assign set_v[vbis_pkg::ST_WSS]      = slc_done_i && is_wss;
	assign set_v[vbis_pkg::ST_VPS]      = slc_done_i && is_vps;
	assign set_v[vbis_pkg::ST_VITC]     = slc_done_i && is_vitc;
	wire [7:0] clr_v   = wr_status ? (reg_wdata_i & vbis_pkg::FLAG_MASK) : 8'h00;
	wire [7:0] flags_d = ((flags_q & ~clr_v) | set_v) & vbis_pkg::FLAG_MASK;
	wire [7:0] status_view = {flags_q[7], fifo_empty, flags_q[5:0]};

	// Line-match condition, only at the start of a line
	wire [5:0] lni_line = lni_q[5:0];
	wire lni_qual = field2_i ? lni_q[vbis_pkg::LNI_F2] : lni_q[vbis_pkg::LNI_F1];
	wire line_hit = hs_fall && lni_qual && (lni_line >= vbis_pkg::LNI_MIN) &&
		(line_num_i == {4'h0, lni_line});

	// Read mux
	wire [7:0] lm_rd = in_lm ? lm_q[lm_widx] : 8'h00;
	wire [7:0] rd_mux =
		(reg_addr_i == vbis_pkg::OFS_STATUS)    ? status_view :
		(reg_addr_i == vbis_pkg::OFS_WCOUNT)    ? count_q :
		(reg_addr_i == vbis_pkg::OFS_THRESH)    ? thresh_q :
		(reg_addr_i == vbis_pkg::OFS_LINE_IRQ)  ? lni_q :
		(reg_addr_i == vbis_pkg::OFS_SW_LO)     ? sw_lo_q :
		(reg_addr_i == vbis_pkg::OFS_SW_HI)     ? {6'h00, sw_hi_q} :
		(reg_addr_i == vbis_pkg::OFS_DRAIN)     ? {7'h00, drain_q} :
		(reg_addr_i == vbis_pkg::OFS_FF_EN)     ? {7'h00, ff_en_q} :
		(reg_addr_i == vbis_pkg::OFS_FF_MODE)   ? ff_mode_q :
		(reg_addr_i == vbis_pkg::OFS_FIFO_DATA) ? (host_take ? head_byte : 8'h00) :
		lm_rd;

	vbis_word_mem #(
		.WIDTH (vbis_pkg::WORD_W),
		.DEPTH (vbis_pkg::FIFO_DEPTH),
		.AW    (vbis_pkg::PTR_W)
	) u_mem (
		.clk_i   (ref_clk_i),
		.we_i    (push),
		.waddr_i (wr_ptr_q),
		.wdata_i (slc_word_i),
		.raddr_i (rd_ptr_q),
		.rdata_o (head_word)
	);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pix_s_q    <= 2'h0;
			hs_s_q     <= 2'h3;
			pix_prev_q <= 1'b0;
			hs_prev_q  <= 1'b1;
			px_q       <= '0;
		end else begin
			pix_s_q    <= {pix_s_q[0], pix_clk_i};
			hs_s_q     <= {hs_s_q[0], hsync_n_i};
			pix_prev_q <= pix_s_q[1];
			hs_prev_q  <= hs_s_q[1];
			if (hs_fall) begin
				px_q <= '0;
			end else if (pix_rise && (px_q != vbis_pkg::PIX_MAX)) begin
				px_q <= px_q + 10'h001;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			thresh_q  <= vbis_pkg::RST_THRESH;
			lni_q     <= vbis_pkg::RST_LINE_IRQ;
			sw_lo_q   <= vbis_pkg::RST_SW_LO;
			sw_hi_q   <= vbis_pkg::RST_SW_HI;
			drain_q   <= vbis_pkg::RST_DRAIN;
			ff_en_q   <= vbis_pkg::RST_FF_EN;
			ff_mode_q <= vbis_pkg::RST_FF_MODE;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				vbis_pkg::OFS_THRESH:   thresh_q  <= reg_wdata_i;
				vbis_pkg::OFS_LINE_IRQ: lni_q     <= reg_wdata_i;
				vbis_pkg::OFS_SW_LO:    sw_lo_q   <= reg_wdata_i;
				vbis_pkg::OFS_SW_HI:    sw_hi_q   <= reg_wdata_i[1:0];
				vbis_pkg::OFS_DRAIN:    drain_q   <= reg_wdata_i[vbis_pkg::CTRL_BIT];
				vbis_pkg::OFS_FF_EN:    ff_en_q   <= reg_wdata_i[vbis_pkg::CTRL_BIT];
				vbis_pkg::OFS_FF_MODE:  ff_mode_q <= reg_wdata_i;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < vbis_pkg::LM_COUNT; i++) begin
				lm_q[i] <= (i == 0) ? vbis_pkg::RST_LM_FIRST : vbis_pkg::RST_LM_REST;
			end
		end else if (wr_lm) begin
			lm_q[lm_widx] <= reg_wdata_i;
		end
	end

	// Line settings, flags and FIFO state
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cur_mode_q <= vbis_pkg::LM_OFF;
			flags_q    <= 8'h00;
			count_q    <= '0;
			wr_ptr_q   <= '0;
			rd_ptr_q   <= '0;
			byte_sel_q <= 1'b0;
			head_ok_q  <= 1'b0;
			line_acc_q <= 1'b0;
		end else begin
			if (switch_hit) begin
				cur_mode_q <= eff_mode;
			end
			flags_q   <= flags_d;
			count_q   <= count_d;
			// Head word is trusted only after a quiet cycle of the memory read
			head_ok_q <= !wr_flush && !pop && !fifo_empty;
			if (wr_flush) begin
				wr_ptr_q   <= '0;
				rd_ptr_q   <= '0;
				byte_sel_q <= 1'b0;
				line_acc_q <= 1'b0;
			end else begin
				if (push) begin
					wr_ptr_q <= wr_ptr_q + 8'h01;
				end
				if (pop) begin
					rd_ptr_q <= rd_ptr_q + 8'h01;
				end
				if (take) begin
					byte_sel_q <= ~byte_sel_q;
				end
				if (admit) begin
					line_acc_q <= 1'b1;
				end else if (slc_done_i || reject) begin
					line_acc_q <= 1'b0;
				end
			end
		end
	end

	// Outputs from flip-flops
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_q  <= 8'h00;
			vid_y_q      <= 8'h00;
			vid_valid_q  <= 1'b0;
			irq_thresh_q <= 1'b0;
			irq_line_q   <= 1'b0;
		end else begin
			if (reg_rd_i) begin
				reg_rdata_q <= rd_mux;
			end
			if (vid_take) begin
				vid_y_q <= head_byte;
			end
			vid_valid_q  <= vid_take;
			irq_thresh_q <= (count_d > thresh_q);
			irq_line_q   <= line_hit;
		end
	end

	assign reg_rdata_o  = reg_rdata_q;
	assign vid_y_o      = vid_y_q;
	assign vid_valid_o  = vid_valid_q;
	assign irq_thresh_o = irq_thresh_q;
	assign irq_line_o   = irq_line_q;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_reject;
		reject && !wr_flush;
	endsequence
	sequence s_admit;
		admit && !slc_done_i;
	endsequence

	a_read_keeps_flags: assert property (!wr_status |=>
		((flags_q & $past(flags_q)) == $past(flags_q)))
		else $error("flag dropped without a clearing write");
	a_w1c_clears: assert property ((wr_status && (set_v == 8'h00)) |=>
		((flags_q & $past(reg_wdata_i) & vbis_pkg::FLAG_MASK) == 8'h00))
		else $error("write-one did not clear flag");
	a_full_reject: assert property (s_reject |=>
		(flags_q[vbis_pkg::ST_FULL_ERR] && !line_acc_q))
		else $error("unfit line not rejected");
	a_fit_admit: assert property (s_admit |=> line_acc_q)
		else $error("fitting line not admitted");
	a_count_read: assert property ((reg_rd_i && reg_addr_i == vbis_pkg::OFS_WCOUNT) |=>
		(reg_rdata_o == $past(count_q)))
		else $error("word count read mismatch");
	a_thresh_level: assert property (##1
		(irq_thresh_o == (count_q > $past(thresh_q))))
		else $error("threshold condition wrong");
	a_flush_empties: assert property (wr_flush |=>
		(count_q == '0) ##1 (!head_ok_q || fifo_empty))
		else $error("flush left data");
	a_line_match: assert property (line_hit |=> irq_line_o)
		else $error("line match not raised");
	a_line_min: assert property (irq_line_o |-> ($past(lni_q[5:0]) >= vbis_pkg::LNI_MIN))
		else $error("line condition for line zero or one");
	a_field_qual: assert property (hs_fall && !field2_i &&
		!lni_q[vbis_pkg::LNI_F1] |=> !irq_line_o)
		else $error("unqualified field fired");
	a_switch_load: assert property (switch_hit |=> (cur_mode_q == $past(eff_mode)))
		else $error("mode not loaded at switch point");
	a_video_path: assert property (vid_valid_o |-> !$past(drain_q))
		else $error("video drain while host access set");
	a_ttx_fifo_only: assert property (is_ttx |-> (!to_regs_o && to_fifo_o))
		else $error("teletext routed to registers");

endmodule : vbis_ctrl

// File: test/vbis_host_model.sv
`timescale 1ns/1ps
module vbis_host_model (
	// Clock
	input  wire logic       ref_clk_i,
	// Register port
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic [7:0]      reg_addr_o,
	output logic [7:0]      reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i
);
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		reg_wr_o = 1'b0;
		// Stale data must not look valid
		reg_wdata_o = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		reg_rd_o = 1'b0;
		d = reg_rdata_i;
		// Spacing keeps FIFO reads out of the refusal window
		@(posedge ref_clk_i);
	endtask : rd
endmodule : vbis_host_model

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0, rst = 1'b1, pix = 1'b0, hs = 1'b1, f2 = 1'b0;
	logic        st = 1'b0, er = 1'b0, wv = 1'b0, dn = 1'b0;
	logic        wr, rd, thr, lirq, vv, tof, nf, df, ed, trg, de;
	logic [7:0]  ad, wd, rdat, vy, b;
	logic [9:0]  ln = 10'h000;
	logic [8:0]  len = 9'h000;
	logic [15:0] w = 16'h0000;
	logic [3:0]  sd;
	logic [7:0]  vq[$];
	int          mismatches = 0, check_count = 0, cyc = 0, hits = 0;

	always #2.5 clk = ~clk;
	always #62.5 pix = ~pix;
	always @(posedge clk) begin
		cyc++;
		if (lirq === 1'b1) hits++;
		if (vv === 1'b1) vq.push_back(vy);
		if (cyc == 30000) begin
			mismatches++;
			summarize();
		end
	end

	vbis_ctrl i_vbis_ctrl (.ref_clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdat), .pix_clk_i(pix),
		.hsync_n_i(hs), .line_num_i(ln), .field2_i(f2), .slc_start_i(st), .slc_len_i(len),
		.slc_err_i(er), .slc_word_valid_i(wv), .slc_word_i(w), .slc_done_i(dn), .std_o(sd),
		.null_filter_o(nf), .data_filter_o(df), .edc_en_o(ed), .to_fifo_o(tof), .to_regs_o(trg),
		.drop_err_o(de), .vid_y_o(vy), .vid_valid_o(vv), .irq_thresh_o(thr), .irq_line_o(lirq));
	vbis_host_model host (.ref_clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(ad),
		.reg_wdata_o(wd), .reg_rdata_i(rdat));

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, b);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, b});
	endtask : rchk
	task automatic line(input logic [9:0] n, input logic f);
		@(posedge clk);
		#1;
		ln = n;
		f2 = f;
		hs = 1'b0;
		repeat (40) @(posedge clk);
		#1;
		hs = 1'b1;
		repeat (300) @(posedge clk);
	endtask : line
	task automatic push(input int n, input logic e);
		@(posedge clk);
		#1;
		st = 1'b1;
		len = 9'(n);
		er = e;
		@(posedge clk);
		#1;
		st = 1'b0;
		for (int i = 0; i < n; i++) begin
			wv = 1'b1;
			w = 16'hA000 + 16'(i);
			@(posedge clk);
			#1;
		end
		wv = 1'b0;
		dn = 1'b1;
		@(posedge clk);
		#1;
		dn = 1'b0;
		repeat (4) @(posedge clk);
	endtask : push

	task automatic t_reset;
		logic [7:0] a[12] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCF, 8'hD0, 8'hD1, 8'hFC,
			8'hC7, 8'hC6, 8'hC0};
		logic [7:0] e[12] = '{8'h80, 8'h00, 8'h4E, 8'h00, 8'h01, 8'h00, 8'h00, 8'hFF, 8'h7F,
			8'h00, 8'h40, 8'h00};
		for (int i = 0; i < 12; i++) rchk(a[i], e[i]);
	endtask : t_reset
	task automatic t_fifo;
		host.wr(8'hCB, 8'h04);
		host.wr(8'hD0, 8'h47);
		host.wr(8'hC8, 8'h01);
		line(10'd6, 1'b0);
		chk("std", 16'h0007, {12'h000, sd});
		chk("to_fifo", 16'h0001, {15'h0000, tof});
		push(2, 1'b0);
		rchk(8'hC7, 8'h02);
		chk("thresh", 16'h0001, {15'h0000, thr});
		rchk(8'hC6, 8'h10);
		push(254, 1'b0);
		rchk(8'hC7, 8'h02);
		rchk(8'hC6, 8'h90);
		push(253, 1'b0);
		rchk(8'hC7, 8'hFF);
		rchk(8'hCE, 8'hA0);
		rchk(8'hCE, 8'h00);
		rchk(8'hC7, 8'hFE);
		rchk(8'hC6, 8'h90);
		host.wr(8'hC6, 8'h80);
		rchk(8'hC6, 8'h10);
		host.wr(8'hC9, 8'h5A);
		rchk(8'hC7, 8'h00);
		rchk(8'hC6, 8'h50);
		chk("thresh", 16'h0000, {15'h0000, thr});
		host.wr(8'hD0, 8'h67);
		line(10'd6, 1'b0);
		push(1, 1'b1);
		rchk(8'hC7, 8'h00);
		push(1, 1'b0);
		rchk(8'hC7, 8'h01);
	endtask : t_fifo
	task automatic t_drain;
		vq.delete();
		host.wr(8'hCD, 8'h00);
		repeat (300) @(posedge clk);
		chk("vid count", 16'h0002, 16'(vq.size()));
		chk("vid word", 16'hA000, {vq[0], vq[1]});
		rchk(8'hC7, 8'h00);
		host.wr(8'hCD, 8'h01);
	endtask : t_drain
	task automatic t_line_irq;
		host.wr(8'hCA, 8'h85);
		hits = 0;
		line(10'd5, 1'b0);
		chk("line irq", 16'h0001, 16'(hits));
		host.wr(8'hCA, 8'hC1);
		hits = 0;
		line(10'd1, 1'b0);
		chk("line irq", 16'h0000, 16'(hits));
		host.wr(8'hCA, 8'h45);
		hits = 0;
		line(10'd5, 1'b0);
		chk("line irq", 16'h0000, 16'(hits));
		line(10'd5, 1'b1);
		chk("line irq", 16'h0001, 16'(hits));
	endtask : t_line_irq
	task automatic t_full;
		logic [7:0] m[3] = '{8'h08, 8'h0C, 8'h0A};
		logic [7:0] e[3] = '{8'h34, 8'h36, 8'h37};
		host.wr(8'hFC, 8'hC6);
		host.wr(8'hCF, 8'h01);
		line(10'd30, 1'b0);
		chk("std", 16'h0006, {12'h000, sd});
		chk("route", 16'h0026, {10'h000, nf, df, ed, tof, trg, de});
		host.wr(8'hFC, 8'hF1);
		line(10'd31, 1'b0);
		chk("route", 16'h001D, {10'h000, nf, df, ed, tof, trg, de});
		push(1, 1'b0);
		rchk(8'hC6, 8'h30);
		for (int i = 0; i < 3; i++) begin
			host.wr(8'hFC, m[i]);
			line(10'd32, 1'b0);
			push(1, 1'b0);
			rchk(8'hC6, e[i]);
		end
	endtask : t_full

	task automatic summarize;
		if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize

	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_fifo();
		t_drain();
		t_line_irq();
		t_full();
		summarize();
	end
endmodule : tb_top
